// >>> tb/tb_top.sv
/*
  Self-checking bench of the two-mode timer.
  Assumes the timer and the far-side model; no other stimulus source.
*/
`timescale 1ns/1ps
`include "tmt_defines.svh"
module tb_top;
  localparam logic [7:0] OVF = 8'h01 << `TMT_CTRL_OVF, EXT = 8'h01 << `TMT_CTRL_EXT;
  localparam logic [7:0] RXS = 8'h01 << `TMT_CTRL_RXCLK, TXS = 8'h01 << `TMT_CTRL_TXCLK;
  localparam logic [7:0] EXEN = 8'h01 << `TMT_CTRL_EXEN, RUN = 8'h01 << `TMT_CTRL_RUN;
  localparam logic [7:0] CTS = 8'h01 << `TMT_CTRL_CTS, CPRL = 8'h01 << `TMT_CTRL_CPRL;
  localparam logic [7:0] C = `TMT_IDX_CTRL, M = `TMT_IDX_MODE;
  localparam logic [7:0] RL = `TMT_IDX_RLD_LO, CL = `TMT_IDX_CNT_LO;
  logic mclk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic cnt_drv = 1'b1, trg = 1'b1, clr = 1'b1;
  logic [31:0] rdat;
  logic ack, pin_o, pin_oe, rx_t, tx_t, irq, pin_lvl;
  logic [7:0] q;
  logic [15:0] v;
  int fails = 0, comparisons = 0, cycles = 0, rx_n, tx_n, edges, high_n, low_n;
  always #4 mclk = ~mclk;
  tmt_timer dut (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .external_count_pin_i(pin_lvl), .external_trigger_pin_i(trg),
    .external_count_pin_o(pin_o), .external_count_pin_oe(pin_oe),
    .rx_shift_tick(rx_t), .tx_shift_tick(tx_t), .timer_irq(irq));
  tmt_far_model far (.mclk(mclk), .clr(clr), .rx_shift_tick(rx_t), .tx_shift_tick(tx_t),
    .pin_o(pin_o), .pin_oe(pin_oe), .pin_drive(cnt_drv), .pin_level(pin_lvl),
    .rx_n(rx_n), .tx_n(tx_n), .edges(edges), .high_n(high_n), .low_n(low_n));
  task automatic report_and_stop();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Ceiling well above the fewer than two thousand cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
  endtask : wait_n
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    sel <= 4'h1;
    // Waits as long as the slave needs; only the cycle ceiling ends a hang
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    check(16'(rdat[31:8] != 24'h0), 16'h0, "read pad");
    @(posedge mclk);
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr
  task automatic wr16(input logic [7:0] lo, input logic [15:0] d);
    xfer(1'b1, lo, d[7:0]);
    xfer(1'b1, lo + 8'h01, d[15:8]);
  endtask : wr16
  task automatic rd16(input logic [7:0] lo);
    xfer(1'b0, lo, 8'h00);
    v[7:0] = q;
    xfer(1'b0, lo + 8'h01, 8'h00);
    v[15:8] = q;
  endtask : rd16
  task automatic flags(input logic [7:0] mask, input logic [7:0] exp, input string msg);
    xfer(1'b0, C, 8'h00);
    check({8'h0, q & mask}, {8'h0, exp}, msg);
  endtask : flags
  // Each level held six cycles, above the three the synchroniser needs
  task automatic pulse(input bit on_trigger);
    if (on_trigger) trg <= 1'b0;
    else cnt_drv <= 1'b0;
    wait_n(6);
    if (on_trigger) trg <= 1'b1;
    else cnt_drv <= 1'b1;
    wait_n(6);
  endtask : pulse
  task automatic t_regs();
    logic [7:0] idx [8];
    idx = '{C, M, RL, RL + 8'h01, CL, CL + 8'h01, `TMT_IDX_CLKCTL, 8'h00};
    foreach (idx[i]) begin
      xfer(1'b0, idx[i], 8'h00);
      check({8'h0, q}, 16'h0, "reset value");
    end
    wr(8'h00, 8'hff);
    xfer(1'b0, 8'h00, 8'h00);
    check({8'h0, q}, 16'h0, "unmapped read");
    wr16(RL, 16'h5aa5);
    rd16(RL);
    check(v, 16'h5aa5, "reload bytes");
    check({15'h0, pin_oe}, 16'h0, "pin enable off");
    $display("done: t_regs");
  endtask : t_regs
  task automatic t_rate(input logic [7:0] ck, input logic [15:0] lo, input logic [15:0] hi);
    wr(`TMT_IDX_CLKCTL, ck);
    wr16(CL, 16'h0000);
    wr(C, RUN);
    wait_n(240);
    wr(C, 8'h00);
    rd16(CL);
    check(16'(v >= lo && v <= hi), 16'h1, "tick rate");
    wait_n(40);
    xfer(1'b0, CL, 8'h00);
    check({8'h0, q}, {8'h0, v[7:0]}, "held while stopped");
    $display("done: t_rate");
  endtask : t_rate
  task automatic t_overflow();
    wr(C, CPRL | CTS);
    wr16(CL, 16'hffff);
    pulse(1'b0);
    rd16(CL);
    check(v, 16'hffff, "stopped ignores pin");
    wr(C, CPRL | CTS | RUN);
    pulse(1'b0);
    rd16(CL);
    check(v, 16'h0000, "rollover");
    flags(OVF, OVF, "overflow flag");
    check({15'h0, irq}, 16'h1, "irq level");
    wr(C, CPRL | CTS | OVF);
    flags(OVF, OVF, "write 1 keeps flag");
    wr(C, 8'h00);
    wait_n(1);
    check({15'h0, irq}, 16'h0, "irq cleared");
    wr(C, EXT);
    wait_n(1);
    check({15'h0, irq}, 16'h1, "forced irq");
    wr(C, 8'h00);
    $display("done: t_overflow");
  endtask : t_overflow
  task automatic t_capture();
    wr16(CL, 16'h5a3c);
    wr(C, CPRL | EXEN | RUN | CTS);
    pulse(1'b1);
    rd16(RL);
    check(v, 16'h5a3c, "captured count");
    flags(EXT, EXT, "capture event");
    wr(C, 8'h00);
    $display("done: t_capture");
  endtask : t_capture
  task automatic t_reload();
    wr16(RL, 16'habcd);
    wr16(CL, 16'hfffe);
    wr(C, EXEN | RUN | CTS);
    pulse(1'b0);
    pulse(1'b0);
    rd16(CL);
    check(v, 16'habcd, "auto reload");
    flags(OVF, OVF, "reload overflow");
    wr16(CL, 16'h1234);
    pulse(1'b1);
    rd16(CL);
    check(v, 16'habcd, "forced reload");
    flags(EXT, EXT, "reload event");
    wr(C, RUN | CTS);
    wr16(CL, 16'h1234);
    pulse(1'b1);
    rd16(CL);
    check(v, 16'h1234, "trigger ignored");
    wr(C, 8'h00);
    $display("done: t_reload");
  endtask : t_reload
  task automatic t_updown();
    wr(M, 8'h01 << `TMT_MODE_DOWN_COUNT_ENABLE);
    wr16(RL, 16'h0010);
    wr16(CL, 16'h0011);
    trg <= 1'b0;
    wr(C, RUN | CTS);
    pulse(1'b0);
    rd16(CL);
    check(v, 16'h0010, "count down");
    pulse(1'b0);
    rd16(CL);
    check(v, 16'hffff, "underflow load");
    flags(OVF | EXT, OVF | EXT, "underflow flags");
    trg <= 1'b1;
    pulse(1'b0);
    rd16(CL);
    check(v, 16'h0010, "count up reload");
    flags(EXT, 8'h00, "seventeenth bit");
    wr(C, 8'h00);
    wr(M, 8'h00);
    $display("done: t_updown");
  endtask : t_updown
  task automatic t_baud();
    wr16(RL, 16'hfff0);
    wr16(CL, 16'hfff0);
    wr(C, TXS | CPRL | RUN);
    clr <= 1'b0;
    wait_n(320);
    check(16'(tx_n >= 9 && tx_n <= 11), 16'h1, "baud ticks");
    check(16'(rx_n), 16'h0, "no rx ticks");
    clr <= 1'b1;
    flags(OVF, 8'h00, "no baud flag");
    wr(C, TXS | CPRL | RUN | EXEN);
    pulse(1'b1);
    flags(EXT, EXT, "baud trigger");
    // Stopped before the count bytes are touched
    wr(C, 8'h00);
    rd16(CL);
    check(16'(v >= 16'hfff0), 16'h1, "reload kept");
    $display("done: t_baud");
  endtask : t_baud
  task automatic t_clkout();
    wr16(RL, 16'hfff0);
    wr16(CL, 16'hfff0);
    // Reload with internal base, then enable, then run
    wr(M, 8'h01 << `TMT_MODE_COE);
    wr(C, RXS | RUN);
    clr <= 1'b0;
    wait_n(320);
    check({15'h0, pin_oe}, 16'h1, "pin driven");
    check(16'(edges >= 9 && edges <= 11), 16'h1, "toggle rate");
    check(16'(rx_n - edges <= 1 && edges - rx_n <= 1), 16'h1, "shared ticks");
    check(16'(high_n - low_n <= 32 && low_n - high_n <= 32), 16'h1, "duty");
    clr <= 1'b1;
    flags(OVF, 8'h00, "no clkout flag");
    wr(C, 8'h00);
    wr(M, 8'h00);
    $display("done: t_clkout");
  endtask : t_clkout
  initial begin
    wait_n(16);
    reset <= 1'b0;
    wait_n(1);
    t_regs();
    t_rate(8'h00, 16'h0013, 16'h0016);
    t_rate(8'h01 << `TMT_CLKCTL_TDIV, 16'h003b, 16'h003f);
    t_overflow();
    t_capture();
    t_reload();
    t_updown();
    t_baud();
    t_clkout();
    report_and_stop();
  end
endmodule : tb_top

// >>> tb/tmt_far_model.sv
/*
  Far-side model: serial port shift-tick consumer and the count pin.
  Assumes the bench gives the level the pin has while the timer leaves it.
*/
`timescale 1ns/1ps
module tmt_far_model (
  input wire logic mclk,
  input wire logic clr,
  input wire logic rx_shift_tick,
  input wire logic tx_shift_tick,
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic pin_drive,
  output logic pin_level,
  output int rx_n,
  output int tx_n,
  output int edges,
  output int high_n,
  output int low_n
);
  logic last_q;
  // Timer owns pin only when enabled
  assign pin_level = pin_oe ? pin_o : pin_drive;
  always_ff @(posedge mclk) begin
    last_q <= pin_level;
    if (clr) begin
      rx_n <= 0;
      tx_n <= 0;
      edges <= 0;
      high_n <= 0;
      low_n <= 0;
    end else begin
      rx_n <= rx_n + int'(rx_shift_tick);
      tx_n <= tx_n + int'(tx_shift_tick);
      edges <= edges + int'(pin_oe && pin_level != last_q);
      high_n <= high_n + int'(pin_oe && pin_level);
      low_n <= low_n + int'(pin_oe && !pin_level);
    end
  end
endmodule : tmt_far_model

// >>> verilog/tmt_defines.svh
/*
  Constants of the two-mode timer: register indexes, control bit positions,
  reset values, tick divisors and count limits.
  Assumes it is included by bare name from each file that needs it.
*/
`ifndef TMT_DEFINES_SVH
`define TMT_DEFINES_SVH

// Register indexes; the Wishbone byte address is four times the index
`define TMT_IDX_CTRL 8'hc8
`define TMT_IDX_MODE 8'hc9
`define TMT_IDX_RLD_LO 8'hca
`define TMT_IDX_RLD_HI 8'hcb
`define TMT_IDX_CNT_LO 8'hcc
`define TMT_IDX_CNT_HI 8'hcd
`define TMT_IDX_CLKCTL 8'h8e
`define TMT_IDX_MSB 9
`define TMT_IDX_LSB 2

// Control register bits
`define TMT_CTRL_OVF 7
`define TMT_CTRL_EXT 6
`define TMT_CTRL_RXCLK 5
`define TMT_CTRL_TXCLK 4
`define TMT_CTRL_EXEN 3
`define TMT_CTRL_RUN 2
`define TMT_CTRL_CTS 1
`define TMT_CTRL_CPRL 0
// Mode register bits
`define TMT_MODE_COE 1
`define TMT_MODE_DOWN_COUNT_ENABLE 0
// Clock control bit: 1 selects divide by 4, 0 divide by 12
`define TMT_CLKCTL_TDIV 5

`define TMT_RST_BYTE 8'h00
`define TMT_RST_BIT 1'b0
`define TMT_RD_PAD 24'h000000

// Oscillator cycles per tick
`define TMT_DIV_SLOW 4'hc
`define TMT_DIV_FAST 4'h4
`define TMT_DIV_BAUD 4'h2

`define TMT_CNT_MAX 16'hffff
`define TMT_CNT_MIN 16'h0000
`define TMT_CNT_ONE 16'h0001

`endif

// >>> verilog/tmt_pkg.sv
/*
  Types shared by the two-mode timer modules.
  Assumes nothing of its surroundings.
*/
package tmt_pkg;
  typedef enum logic [1:0] {
    TMT_RATE_12,
    TMT_RATE_4,
    TMT_RATE_2
  } tmt_rate_t;
endpackage : tmt_pkg

// >>> verilog/tmt_sync.sv
/*
  Two-flop synchronisers with falling-edge detection for external pins.
  Assumes raw asynchronous pin levels; edges come from the synced samples.
*/
`timescale 1ns/1ps
module tmt_sync #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin_raw,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      always_ff @(posedge mclk) begin
        if (reset) begin
          meta_q[i] <= 1'b1;
          sync_q[i] <= 1'b1;
          prev_q[i] <= 1'b1;
        end else begin
          meta_q[i] <= pin_raw[i];
          sync_q[i] <= meta_q[i];
          prev_q[i] <= sync_q[i];
        end
      end
      // Edge taken from the second and third flops only
      assign fall[i] = prev_q[i] & ~sync_q[i];
    end
  endgenerate

  assign level = sync_q;
endmodule : tmt_sync

// >>> verilog/tmt_tick.sv
/*
  Oscillator tick divider: one-cycle pulse every 12, 4 or 2 clocks.
  Assumes the rate select comes from logic on the same clock.
*/
`timescale 1ns/1ps
`include "tmt_defines.svh"
module tmt_tick #(
  parameter int CW = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input tmt_pkg::tmt_rate_t rate,
  output logic tick
);
  import tmt_pkg::*;

  logic [CW-1:0] div_cnt_q;
  logic [CW-1:0] div_cnt_d;
  logic tick_q;
  logic [CW-1:0] div_last;
  logic wrap;

  assign div_last = (rate == TMT_RATE_2) ? CW'(`TMT_DIV_BAUD - 4'h1) :
                    (rate == TMT_RATE_4) ? CW'(`TMT_DIV_FAST - 4'h1) :
                    CW'(`TMT_DIV_SLOW - 4'h1);
  // Compare with >= so a rate change mid-period cannot strand the counter
  assign wrap = (div_cnt_q >= div_last);
  assign div_cnt_d = wrap ? '0 : div_cnt_q + CW'(1);
  assign tick = tick_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      div_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      tick_q <= wrap;
    end
  end
endmodule : tmt_tick

// >>> verilog/tmt_timer.sv
/*
  Two-mode 16-bit timer/counter with capture, auto-reload, up/down count,
  baud tick generation and clock output, behind a classic Wishbone slave.
  Assumes raw external pins, one clock, and that the serial port and the
  interrupt controller sit outside and consume the ticks and flag outputs.
*/
// What this block does
// - Counter is always sixteen bits; no thirteen-bit or split byte modes.
// - Count source select 1 counts falling edges of the external count pin.
// - Count source select 0 counts oscillator divided by 12 or by 4.
// - Counting only while run bit is set; otherwise count holds except for a trigger-forced reload.
// - Rollover FFFFh to 0000h sets the overflow flag.
// - Capture mode: trigger falling edge copies count into capture bytes.
// - Reload select 0 uses capture bytes as reload value; modes exclusive.
// - Auto-reload overflow sets flag, loads reload value, keeps counting.
// - Auto-reload with trigger enable: trigger falling edge forces reload.
// - Down-count enable: trigger pin high counts up, low counts down.
// - Counting down, count equal to reload value loads FFFFh.
// - Up/down mode: each overflow or underflow toggles external event flag.
// - Receive or transmit clock select forces sixteen-bit auto-reload.
// - Baud mode overflow gives serial shift clock, not the overflow flag.
// - Baud mode trigger falling edge sets external event flag.
// - Baud mode timebase is oscillator divided by 2, or the count pin.
// - Clock output mode toggles count pin on each overflow.
// - Clock output mode: divide by 2, no overflow flag, trigger still flags.
// - Clock output with baud select: same overflows drive pin and shift clock.
// - Writing 1 to external event flag raises it; software clears it.
// - Output enable 0 leaves count pin as input, not driven.
`timescale 1ns/1ps
`include "tmt_defines.svh"
module tmt_timer #(
  parameter int ADDR_W = 10
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_count_pin_i,
  input wire logic external_trigger_pin_i,
  output logic external_count_pin_o,
  output logic external_count_pin_oe,
  output logic rx_shift_tick,
  output logic tx_shift_tick,
  output logic timer_irq
);
  import tmt_pkg::*;

  function automatic logic reg_hit(input logic [7:0] idx, input logic [7:0] want);
    reg_hit = (idx == want);
  endfunction : reg_hit

  // Register state
  logic [7:0] cnt_lo_q, cnt_hi_q, rld_lo_q, rld_hi_q;
  logic [7:0] cnt_lo_d, cnt_hi_d, rld_lo_d, rld_hi_d;
  logic overflow_flag_q, overflow_flag_d;
  logic external_event_flag_q, external_event_flag_d;
  logic rx_clock_select_q, tx_clock_select_q, external_trigger_enable_q;
  logic timer_run_q, count_source_select_q, capture_reload_select_q;
  logic clock_output_enable_q, down_count_enable_q, tick_divider_select_q;
  logic ack_q, ack_d;
  logic [31:0] dat_q;
  logic pin_q, pin_d, oe_q, rxs_q, rxs_d, txs_q, txs_d, irq_q;

  // Bus decode
  logic [7:0] idx;
  logic req, wr_commit;
  logic wr_ctl, wr_mode, wr_clk, wr_rlo, wr_rhi, wr_clo, wr_chi;
  logic [7:0] wdat, rd_byte, ctl_rd, mode_rd, clk_rd;

  assign idx = wb_adr_i[`TMT_IDX_MSB:`TMT_IDX_LSB];
  assign req = wb_cyc_i & wb_stb_i;
  // Registers change at the edge where the master sees ack
  assign wr_commit = req & ack_q & wb_we_i & wb_sel_i[0];
  assign wdat = wb_dat_i[7:0];
  assign wr_ctl = wr_commit & reg_hit(idx, `TMT_IDX_CTRL);
  assign wr_mode = wr_commit & reg_hit(idx, `TMT_IDX_MODE);
  assign wr_clk = wr_commit & reg_hit(idx, `TMT_IDX_CLKCTL);
  assign wr_rlo = wr_commit & reg_hit(idx, `TMT_IDX_RLD_LO);
  assign wr_rhi = wr_commit & reg_hit(idx, `TMT_IDX_RLD_HI);
  assign wr_clo = wr_commit & reg_hit(idx, `TMT_IDX_CNT_LO);
  assign wr_chi = wr_commit & reg_hit(idx, `TMT_IDX_CNT_HI);
  assign ack_d = req & ~ack_q;

  assign ctl_rd = {overflow_flag_q, external_event_flag_q, rx_clock_select_q,
                   tx_clock_select_q, external_trigger_enable_q, timer_run_q,
                   count_source_select_q, capture_reload_select_q};
  assign mode_rd = {6'h00, clock_output_enable_q, down_count_enable_q};
  assign clk_rd = {2'h0, tick_divider_select_q, 5'h00};
  // Unmapped addresses answer with zero
  assign rd_byte = reg_hit(idx, `TMT_IDX_CTRL) ? ctl_rd :
                   reg_hit(idx, `TMT_IDX_MODE) ? mode_rd :
                   reg_hit(idx, `TMT_IDX_CLKCTL) ? clk_rd :
                   reg_hit(idx, `TMT_IDX_RLD_LO) ? rld_lo_q :
                   reg_hit(idx, `TMT_IDX_RLD_HI) ? rld_hi_q :
                   reg_hit(idx, `TMT_IDX_CNT_LO) ? cnt_lo_q :
                   reg_hit(idx, `TMT_IDX_CNT_HI) ? cnt_hi_q : `TMT_RST_BYTE;

  // Pin synchronisers and tick source
  logic [1:0] pin_lvl, pin_fall;
  logic trig_lvl, trig_fall, cnt_fall, base_tick;
  tmt_rate_t rate;
  logic baud_mode, clkout_mode, fast_base, capture_mode, reload_mode, updown;

  tmt_sync #(
    .WIDTH(2)
  ) u_sync (
    .mclk(mclk),
    .reset(reset),
    .pin_raw({external_trigger_pin_i, external_count_pin_i}),
    .level(pin_lvl),
    .fall(pin_fall)
  );
  assign trig_lvl = pin_lvl[1];
  assign trig_fall = pin_fall[1];
  assign cnt_fall = pin_fall[0];

  assign baud_mode = rx_clock_select_q | tx_clock_select_q;
  assign clkout_mode = clock_output_enable_q;
  assign fast_base = baud_mode | clkout_mode;
  assign rate = fast_base ? TMT_RATE_2 :
                (tick_divider_select_q ? TMT_RATE_4 : TMT_RATE_12);

  tmt_tick #(
    .CW(4)
  ) u_tick (
    .mclk(mclk),
    .reset(reset),
    .rate(rate),
    .tick(base_tick)
  );

  assign capture_mode = capture_reload_select_q & ~baud_mode;
  assign reload_mode = ~capture_mode;
  assign updown = down_count_enable_q & reload_mode & ~baud_mode;

  // Counting datapath
  logic [15:0] cnt, rld, cnt_step, cnt_hw;
  logic src_tick, step, down, at_max, ovf_ev, unf_ev;
  logic trig_ev, cap_ev, force_rl, flag_ev, toggle_ev, ext_set, ext_base;

  assign cnt = {cnt_hi_q, cnt_lo_q};
  assign rld = {rld_hi_q, rld_lo_q};
  assign src_tick = count_source_select_q ? cnt_fall : base_tick;
  assign step = timer_run_q & src_tick;
  assign down = updown & ~trig_lvl;
  assign at_max = (cnt == `TMT_CNT_MAX);
  assign ovf_ev = step & ~down & at_max;
  assign unf_ev = step & down & (cnt == rld);
  assign trig_ev = external_trigger_enable_q & trig_fall;
  assign cap_ev = capture_mode & trig_ev;
  assign force_rl = reload_mode & ~baud_mode & ~updown & trig_ev;

  assign cnt_step = down ? (unf_ev ? `TMT_CNT_MAX : cnt - `TMT_CNT_ONE) :
                    at_max ? (reload_mode ? rld : `TMT_CNT_MIN) :
                    cnt + `TMT_CNT_ONE;
  assign cnt_hw = force_rl ? rld : (step ? cnt_step : cnt);
  // Writing a running fast counter may corrupt it; software stops it first
  assign cnt_lo_d = wr_clo ? wdat : cnt_hw[7:0];
  assign cnt_hi_d = wr_chi ? wdat : cnt_hw[15:8];
  // Capture beats a same-cycle write so no edge is lost
  assign rld_lo_d = cap_ev ? cnt_lo_q : (wr_rlo ? wdat : rld_lo_q);
  assign rld_hi_d = cap_ev ? cnt_hi_q : (wr_rhi ? wdat : rld_hi_q);

  assign flag_ev = (ovf_ev | unf_ev) & ~baud_mode & ~clkout_mode;
  assign overflow_flag_d = flag_ev |
                           (overflow_flag_q & ~(wr_ctl & ~wdat[`TMT_CTRL_OVF]));
  assign toggle_ev = updown & (ovf_ev | unf_ev);
  assign ext_set = trig_ev & ~updown;
  assign ext_base = wr_ctl ? wdat[`TMT_CTRL_EXT] : external_event_flag_q;
  assign external_event_flag_d = toggle_ev ? ~ext_base : (ext_base | ext_set);

  assign rxs_d = baud_mode & ovf_ev & rx_clock_select_q;
  assign txs_d = baud_mode & ovf_ev & tx_clock_select_q;
  assign pin_d = (clkout_mode & ovf_ev) ? ~pin_q : pin_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_q <= `TMT_RST_BIT;
      dat_q <= {`TMT_RD_PAD, `TMT_RST_BYTE};
    end else begin
      ack_q <= ack_d;
      dat_q <= ack_d ? {`TMT_RD_PAD, rd_byte} : dat_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      {rx_clock_select_q, tx_clock_select_q, external_trigger_enable_q} <= '0;
      {timer_run_q, count_source_select_q, capture_reload_select_q} <= '0;
    end else if (wr_ctl) begin
      rx_clock_select_q <= wdat[`TMT_CTRL_RXCLK];
      tx_clock_select_q <= wdat[`TMT_CTRL_TXCLK];
      external_trigger_enable_q <= wdat[`TMT_CTRL_EXEN];
      timer_run_q <= wdat[`TMT_CTRL_RUN];
      count_source_select_q <= wdat[`TMT_CTRL_CTS];
      capture_reload_select_q <= wdat[`TMT_CTRL_CPRL];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      {clock_output_enable_q, down_count_enable_q, tick_divider_select_q} <= '0;
    end else begin
      clock_output_enable_q <= wr_mode ? wdat[`TMT_MODE_COE] : clock_output_enable_q;
      down_count_enable_q <= wr_mode ? wdat[`TMT_MODE_DOWN_COUNT_ENABLE] : down_count_enable_q;
      tick_divider_select_q <= wr_clk ? wdat[`TMT_CLKCTL_TDIV] : tick_divider_select_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      {cnt_hi_q, cnt_lo_q, rld_hi_q, rld_lo_q} <= {4{`TMT_RST_BYTE}};
      overflow_flag_q <= `TMT_RST_BIT;
      external_event_flag_q <= `TMT_RST_BIT;
    end else begin
      {cnt_hi_q, cnt_lo_q} <= {cnt_hi_d, cnt_lo_d};
      {rld_hi_q, rld_lo_q} <= {rld_hi_d, rld_lo_d};
      overflow_flag_q <= overflow_flag_d;
      external_event_flag_q <= external_event_flag_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      {pin_q, oe_q, rxs_q, txs_q, irq_q} <= '0;
    end else begin
      pin_q <= pin_d;
      oe_q <= clock_output_enable_q;
      rxs_q <= rxs_d;
      txs_q <= txs_d;
      irq_q <= overflow_flag_q | external_event_flag_q;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign external_count_pin_o = pin_q;
  assign external_count_pin_oe = oe_q;
  assign rx_shift_tick = rxs_q;
  assign tx_shift_tick = txs_q;
  assign timer_irq = irq_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  ack_one_cycle_a: assert property (req && !ack_q |=> ack_q ##1 !ack_q)
    else $error("ack not a single cycle pulse");
  ovf_flag_set_a: assert property (flag_ev |=> overflow_flag_q)
    else $error("overflow flag not set on rollover");
  baud_no_flag_a: assert property (baud_mode && !overflow_flag_q |=> !overflow_flag_q)
    else $error("overflow flag set in baud mode");
  hold_stopped_a: assert property (!timer_run_q && !force_rl && !wr_clo && !wr_chi
      |=> cnt == $past(cnt))
    else $error("count moved while stopped");
  reload_on_ovf_a: assert property (ovf_ev && reload_mode && !wr_clo && !wr_chi
      |=> cnt == $past(rld))
    else $error("reload value not loaded on overflow");
  capture_copy_a: assert property (cap_ev |=> rld == $past(cnt))
    else $error("capture did not copy count");
  underflow_max_a: assert property (unf_ev && !wr_clo && !wr_chi
      |=> cnt == `TMT_CNT_MAX)
    else $error("underflow did not load all ones");
  down_step_a: assert property (step && down && !unf_ev && !wr_clo && !wr_chi
      |=> cnt == $past(cnt) - `TMT_CNT_ONE)
    else $error("down count step wrong");
  tx_shift_a: assert property (ovf_ev && baud_mode && tx_clock_select_q
      |=> tx_shift_tick)
    else $error("missing transmit shift tick");
  seventeen_bit_a: assert property (toggle_ev && !wr_ctl
      |=> external_event_flag_q != $past(external_event_flag_q))
    else $error("event flag did not toggle");
  clkout_toggle_a: assert property (ovf_ev && clkout_mode
      |=> external_count_pin_o != $past(external_count_pin_o))
    else $error("clock output pin did not toggle");
  up_step_a: assert property (step && !down && !at_max && !force_rl
      && !wr_clo && !wr_chi |=> cnt == $past(cnt) + `TMT_CNT_ONE)
    else $error("count did not step up");
  rollover_zero_a: assert property (ovf_ev && capture_mode && !wr_clo && !wr_chi
      |=> cnt == `TMT_CNT_MIN)
    else $error("rollover did not give zero");
  force_reload_a: assert property (force_rl && !wr_clo && !wr_chi
      |=> cnt == $past(rld))
    else $error("trigger did not force reload");
  ext_set_a: assert property (ext_set
      |=> external_event_flag_q)
    else $error("event flag not set by trigger");
  clkout_no_flag_a: assert property (clkout_mode && !overflow_flag_q
      |=> !overflow_flag_q)
    else $error("overflow flag set in clock output mode");
  rx_shift_a: assert property (ovf_ev && baud_mode && rx_clock_select_q
      |=> rx_shift_tick)
    else $error("missing receive shift tick");
  no_tick_idle_a: assert property (!baud_mode
      |=> !rx_shift_tick && !tx_shift_tick)
    else $error("shift tick outside baud mode");
  pin_hold_a: assert property (!(clkout_mode && ovf_ev)
      |=> $stable(external_count_pin_o))
    else $error("clock output pin moved without overflow");
  oe_off_a: assert property (!clock_output_enable_q
      |=> !external_count_pin_oe)
    else $error("count pin driven while output disabled");
  count_src_a: assert property (count_source_select_q && !cnt_fall && !force_rl
      && !wr_clo && !wr_chi |=> cnt == $past(cnt))
    else $error("count moved without a pin edge");
  ovf_clear_a: assert property (wr_ctl && !wdat[`TMT_CTRL_OVF] && !flag_ev
      |=> !overflow_flag_q)
    else $error("overflow flag not cleared by write");
  ovf_hw_only_a: assert property (!flag_ev && !overflow_flag_q
      |=> !overflow_flag_q)
    else $error("overflow flag set without an event");
  one_fall_a: assert property (trig_fall
      |=> !trig_fall)
    else $error("trigger edge seen twice");
  reload_hold_a: assert property (!cap_ev && !wr_rlo && !wr_rhi
      |=> rld == $past(rld))
    else $error("reload value changed unasked");
endmodule : tmt_timer
